// ### src/crs_regs.vh
// register set constants: field positions, reset values, widths and timing
`ifndef CRS_REGS_VH
`define CRS_REGS_VH
`define CRS_EXR_TRACE_BIT     7
`define CRS_EXR_RSVD_HI       6
`define CRS_EXR_RSVD_LO       3
`define CRS_EXR_RSVD_MASK     8'h78
`define CRS_EXR_LEVEL_MASK    8'h07
`define CRS_EXR_RESET         8'h7F
`define CRS_CCR_IMASK_BIT     7
`define CRS_CCR_USER_BIT      6
`define CRS_CCR_N_BIT         3
`define CRS_CCR_Z_BIT         2
`define CRS_CCR_V_BIT         1
`define CRS_CCR_C_BIT         0
`define CRS_CCR_RESET         8'h80
`define CRS_CTL_LOAD          3'h1
`define CRS_CTL_STORE         3'h2
`define CRS_CTL_AND           3'h3
`define CRS_CTL_OR            3'h4
`define CRS_CTL_XOR           3'h5
`define CRS_IRQ_HOLD_STATES   2'h3
`define CRS_SP_INDEX          3'h7
`define CRS_VIEW_32           2'h0
`define CRS_VIEW_E16          2'h1
`define CRS_VIEW_R16          2'h2
`define CRS_VIEW_8            2'h3
`define CRS_NARROW_ADDR_MASK  24'h00FFFF
`define CRS_WIDE_ADDR_MASK    24'hFFFFFF
`define CRS_MUL_ACC_UPPER_VALID_BITS   10
`endif

// ### src/crs_gpr_file.v
// eight-entry 32-bit general register memory with registered read data
`timescale 1ns/100ps
module crs_gpr_file #(
  parameter DEPTH_LOG2 = 3,
  parameter WIDTH      = 32
) (
  input  wire                  i_clock,
  input  wire [DEPTH_LOG2-1:0] i_waddr,
  input  wire [WIDTH-1:0]      i_wdata,
  input  wire [WIDTH-1:0]      i_wmask,
  input  wire                  i_we,
  input  wire [DEPTH_LOG2-1:0] i_raddr,
  output wire [WIDTH-1:0]      o_rdata,
  input  wire [DEPTH_LOG2-1:0] i_sp_addr,
  output wire [WIDTH-1:0]      o_sp_data
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
  reg [WIDTH-1:0] rdata_q;
  reg [WIDTH-1:0] sp_q;

  // not reset: contents are uninitialised after reset
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= (mem[i_waddr] & ~i_wmask) | (i_wdata & i_wmask);
    end
    rdata_q <= mem[i_raddr];
    sp_q    <= mem[i_sp_addr];
  end

  assign o_rdata   = rdata_q;
  assign o_sp_data = sp_q;
endmodule // crs_gpr_file

// ### src/crs_register_set.v
// cpu programmer-visible register set: general registers and control registers
//
// How it works
// - narrow config masks addresses to 64 kbytes, wide config to 16 Mbytes.
// - eight identical 32-bit general registers, read/written at 32, 16 or 8 bits.
// - each general register splits into independent upper and lower 16-bit halves.
// - lower half splits into independent high and low bytes; view chosen per access.
// - last general register doubles as the stack pointer for push and pop.
// - program counter is a 24-bit register of the next instruction address.
// - instruction fetch address forces program counter bit 0 to zero.
// - load/and/or/xor of extended control holds off all interrupts three states.
// - extended control bit 7 is trace, reset 0; when set, trace after each instruction.
// - extended control bits 6 to 3 always read as one.
// - extended control bits 2 to 0 are a writable mask level, reset to ones.
// - condition-code bit 7 masks all but non-maskable interrupt; resets to one.
// - condition-code interrupt mask set to one when exception handling starts.
// - condition-code bit 6 is a plain user bit with no masking effect.
// - condition-code register supports load, store, and, or, xor operations.
// - negative, zero, overflow and carry flags drive branch condition evaluation.
// - 64-bit multiply-accumulate register sits beside program counter and controls.
// - reset clears pc (vector loaded after release), clears trace, sets both mask fields to one.
// - accumulate upper half keeps 10 bits; bits above read as sign extension.
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_register_set #(
  parameter PC_WIDTH   = 24,
  parameter GPR_WIDTH  = 32
) (
  input  wire                 i_clock,
  input  wire                 i_nrst,
  input  wire                 i_wide_addr,
  input  wire [2:0]           i_gpr_waddr,
  input  wire [1:0]           i_gpr_wview,
  input  wire                 i_gpr_wbyte_hi,
  input  wire                 i_gpr_we,
  input  wire [31:0]          i_gpr_wdata,
  input  wire [2:0]           i_gpr_raddr,
  input  wire [1:0]           i_gpr_rview,
  input  wire                 i_gpr_rbyte_hi,
  output wire [31:0]          o_gpr_rdata,
  input  wire                 i_sp_we,
  input  wire [31:0]          i_sp_wdata,
  output wire [31:0]          o_stack_pointer,
  input  wire                 i_pc_load,
  input  wire [PC_WIDTH-1:0]  i_pc_wdata,
  input  wire                 i_reset_vector_valid,
  input  wire [PC_WIDTH-1:0]  i_reset_vector,
  output wire [PC_WIDTH-1:0]  o_pc,
  output wire [PC_WIDTH-1:0]  o_fetch_addr,
  input  wire [2:0]           i_exr_op,
  input  wire [7:0]           i_exr_operand,
  output wire [7:0]           o_extended_control,
  input  wire [2:0]           i_ccr_op,
  input  wire [7:0]           i_ccr_operand,
  input  wire                 i_flags_we,
  input  wire [3:0]           i_flags_nzvc,
  input  wire                 i_exception_start,
  output wire [7:0]           o_condition_code,
  input  wire [3:0]           i_branch_cond,
  output wire                 o_branch_taken,
  input  wire                 i_insn_done,
  output reg                  o_trace_request,
  output wire                 o_irq_hold,
  output wire                 o_maskable_irq_block,
  output wire [2:0]           o_mask_level,
  input  wire                 i_mac_we_lo,
  input  wire                 i_mac_we_hi,
  input  wire [31:0]          i_mac_wdata,
  output wire [63:0]          o_mul_acc_result
);
  // byte lane masks for each access view
  function [31:0] view_mask;
    input [1:0] view;
    input       byte_hi;
    begin
      case (view)
        `CRS_VIEW_32:  view_mask = 32'hFFFFFFFF;
        `CRS_VIEW_E16: view_mask = 32'hFFFF0000;
        `CRS_VIEW_R16: view_mask = 32'h0000FFFF;
        default:       view_mask = byte_hi ? 32'h0000FF00 : 32'h000000FF;
      endcase
    end
  endfunction

  // place narrow write data into its lane
  function [31:0] view_place;
    input [1:0]  view;
    input        byte_hi;
    input [31:0] data;
    begin
      case (view)
        `CRS_VIEW_32:  view_place = data;
        `CRS_VIEW_E16: view_place = {data[15:0], 16'h0000};
        `CRS_VIEW_R16: view_place = {16'h0000, data[15:0]};
        default:       view_place = byte_hi ? {16'h0000, data[7:0], 8'h00}
                                            : {24'h000000, data[7:0]};
      endcase
    end
  endfunction

  // apply a control-register instruction; store leaves the value alone
  function [7:0] ctl_apply;
    input [2:0] op;
    input [7:0] cur;
    input [7:0] opnd;
    begin
      case (op)
        `CRS_CTL_LOAD: ctl_apply = opnd;
        `CRS_CTL_AND:  ctl_apply = cur & opnd;
        `CRS_CTL_OR:   ctl_apply = cur | opnd;
        `CRS_CTL_XOR:  ctl_apply = cur ^ opnd;
        default:       ctl_apply = cur;
      endcase
    end
  endfunction

  function ctl_modifies;
    input [2:0] op;
    begin
      ctl_modifies = (op == `CRS_CTL_LOAD) || (op == `CRS_CTL_AND) ||
                     (op == `CRS_CTL_OR) || (op == `CRS_CTL_XOR);
    end
  endfunction

  // general registers; stack-pointer writes win over a same-cycle port write
  reg  [1:0]  rview_q;
  reg         rbyte_hi_q;
  wire [31:0] mem_rdata;
  wire [31:0] sp_rdata;
  wire        gpr_we      = i_gpr_we | i_sp_we;
  wire [2:0]  gpr_waddr   = i_sp_we ? `CRS_SP_INDEX : i_gpr_waddr;
  wire [31:0] gpr_wmask   = i_sp_we ? 32'hFFFFFFFF
                                    : view_mask(i_gpr_wview, i_gpr_wbyte_hi);
  wire [31:0] gpr_wdata   = i_sp_we ? i_sp_wdata
                                    : view_place(i_gpr_wview, i_gpr_wbyte_hi, i_gpr_wdata);

  crs_gpr_file #(
    .DEPTH_LOG2 (3),
    .WIDTH      (GPR_WIDTH)
  ) u_gpr (
    .i_clock   (i_clock),
    .i_waddr   (gpr_waddr),
    .i_wdata   (gpr_wdata),
    .i_wmask   (gpr_wmask),
    .i_we      (gpr_we),
    .i_raddr   (i_gpr_raddr),
    .o_rdata   (mem_rdata),
    .i_sp_addr (`CRS_SP_INDEX),
    .o_sp_data (sp_rdata)
  );

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rview_q    <= `CRS_VIEW_32;
      rbyte_hi_q <= 1'b0;
    end else begin
      rview_q    <= i_gpr_rview;
      rbyte_hi_q <= i_gpr_rbyte_hi;
    end
  end

  // read views right-justify the selected lane
  reg [31:0] gpr_rview_d;
  always @* begin
    case (rview_q)
      `CRS_VIEW_32:  gpr_rview_d = mem_rdata;
      `CRS_VIEW_E16: gpr_rview_d = {16'h0000, mem_rdata[31:16]};
      `CRS_VIEW_R16: gpr_rview_d = {16'h0000, mem_rdata[15:0]};
      default:       gpr_rview_d = rbyte_hi_q ? {24'h000000, mem_rdata[15:8]}
                                              : {24'h000000, mem_rdata[7:0]};
    endcase
  end
  assign o_gpr_rdata     = gpr_rview_d;
  assign o_stack_pointer = sp_rdata;

  // address span of the selected mode; both configurations share one mask decode
  function [23:0] span_mask;
    input wide;
    begin
      span_mask = wide ? `CRS_WIDE_ADDR_MASK : `CRS_NARROW_ADDR_MASK;
    end
  endfunction

  // mode pin comes from outside the clock: three stages, taken once the last two agree;
  // the reset vector must not arrive before the pin has settled, four clocks after release
  reg  [2:0] wide_sync_q;
  reg        wide_mode_q;
  reg        wide_mode_d;
  always @* begin
    wide_mode_d = wide_mode_q;
    if (wide_sync_q[2] == wide_sync_q[1]) begin
      wide_mode_d = wide_sync_q[2];
    end
  end
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wide_sync_q <= 3'h0;
      wide_mode_q <= 1'b0;
    end else begin
      wide_sync_q <= {wide_sync_q[1:0], i_wide_addr};
      wide_mode_q <= wide_mode_d;
    end
  end

  // program counter; the reset vector is taken after release, not under reset
  reg  [PC_WIDTH-1:0] pc_q;
  reg  [PC_WIDTH-1:0] pc_d;
  reg  [PC_WIDTH-1:0] fetch_q;
  reg                 vec_pending_q;
  wire [PC_WIDTH-1:0] addr_mask  = span_mask(wide_mode_q);
  wire [PC_WIDTH-1:0] fetch_mask = span_mask(wide_mode_d);
  always @* begin
    pc_d = pc_q;
    if (vec_pending_q) begin
      if (i_reset_vector_valid) begin
        pc_d = i_reset_vector & addr_mask;
      end
    end else if (i_pc_load) begin
      pc_d = i_pc_wdata & addr_mask;
    end
  end
  // fetch address leaves from a flop, with pc bit 0 ignored
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_q          <= {PC_WIDTH{1'b0}};
      fetch_q       <= {PC_WIDTH{1'b0}};
      vec_pending_q <= 1'b1;
    end else begin
      pc_q          <= pc_d;
      fetch_q       <= {pc_d[PC_WIDTH-1:1], 1'b0} & fetch_mask;
      if (vec_pending_q && i_reset_vector_valid) begin
        vec_pending_q <= 1'b0;
      end
    end
  end
  assign o_pc         = pc_q;
  assign o_fetch_addr = fetch_q;

  // extended control: trace and mask level are the only stored bits
  reg        trace_q;
  reg [2:0]  level_q;
  wire [7:0] exr_view = {trace_q, 4'hF, level_q};
  wire [7:0] exr_next = ctl_apply(i_exr_op, exr_view, i_exr_operand);
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      trace_q <= 1'b0;
      level_q <= 3'h7;
    end else if (ctl_modifies(i_exr_op)) begin
      trace_q <= exr_next[`CRS_EXR_TRACE_BIT];
      level_q <= exr_next[2:0];
    end
  end
  assign o_extended_control = exr_view | `CRS_EXR_RSVD_MASK;
  assign o_mask_level       = level_q;

  // interrupt hold-off for three states after a modifying extended control op
  reg [1:0] hold_cnt_q;
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_cnt_q <= 2'h0;
    end else if (ctl_modifies(i_exr_op)) begin
      hold_cnt_q <= `CRS_IRQ_HOLD_STATES;
    end else if (hold_cnt_q != 2'h0) begin
      hold_cnt_q <= hold_cnt_q - 2'h1;
    end
  end
  assign o_irq_hold = (hold_cnt_q != 2'h0);

  // condition code; exception start forces the mask over any same-cycle op
  reg  [7:0] ccr_q;
  reg  [7:0] ccr_d;
  always @* begin
    ccr_d = ctl_apply(i_ccr_op, ccr_q, i_ccr_operand);
    if (i_flags_we && !ctl_modifies(i_ccr_op)) begin
      ccr_d[3:0] = i_flags_nzvc;
    end
    if (i_exception_start) begin
      ccr_d[`CRS_CCR_IMASK_BIT] = 1'b1;
    end
  end
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ccr_q <= `CRS_CCR_RESET;
    end else begin
      ccr_q <= ccr_d;
    end
  end
  assign o_condition_code     = ccr_q;
  assign o_maskable_irq_block = ccr_q[`CRS_CCR_IMASK_BIT];

  // branch condition evaluation over n, z, v, c
  wire fn = ccr_q[`CRS_CCR_N_BIT];
  wire fz = ccr_q[`CRS_CCR_Z_BIT];
  wire fv = ccr_q[`CRS_CCR_V_BIT];
  wire fc = ccr_q[`CRS_CCR_C_BIT];
  reg  br_d;
  always @* begin
    case (i_branch_cond)
      4'h0:    br_d = 1'b1;
      4'h1:    br_d = 1'b0;
      4'h2:    br_d = ~(fc | fz);
      4'h3:    br_d = fc | fz;
      4'h4:    br_d = ~fc;
      4'h5:    br_d = fc;
      4'h6:    br_d = ~fz;
      4'h7:    br_d = fz;
      4'h8:    br_d = ~fv;
      4'h9:    br_d = fv;
      4'hA:    br_d = ~fn;
      4'hB:    br_d = fn;
      4'hC:    br_d = ~(fn ^ fv);
      4'hD:    br_d = fn ^ fv;
      4'hE:    br_d = ~(fz | (fn ^ fv));
      default: br_d = fz | (fn ^ fv);
    endcase
  end
  assign o_branch_taken = br_d;

  // trace request after each completed instruction while trace is set
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_trace_request <= 1'b0;
    end else begin
      o_trace_request <= i_insn_done & trace_q;
    end
  end

  // multiply-accumulate: upper half stores its valid bits only
  localparam MV = `CRS_MUL_ACC_UPPER_VALID_BITS;
  reg [31:0]   mac_lo_q;
  reg [MV-1:0] mac_hi_q;
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mac_lo_q <= 32'h00000000;
      mac_hi_q <= {MV{1'b0}};
    end else begin
      if (i_mac_we_lo) begin
        mac_lo_q <= i_mac_wdata;
      end
      if (i_mac_we_hi) begin
        mac_hi_q <= i_mac_wdata[MV-1:0];
      end
    end
  end
  assign o_mul_acc_result = {{(32-MV){mac_hi_q[MV-1]}}, mac_hi_q, mac_lo_q};
endmodule // crs_register_set

// ### dv/crs_register_set_sva.sv
// checker for the cpu register set outputs
`timescale 1ns/100ps
module crs_register_set_sva #(
  parameter PC_WIDTH = 24
) (
  input wire                i_clock,
  input wire                i_nrst,
  input wire                i_wide_addr,
  input wire [2:0]          i_exr_op,
  input wire                i_exception_start,
  input wire                i_insn_done,
  input wire [PC_WIDTH-1:0] o_fetch_addr,
  input wire [7:0]          o_extended_control,
  input wire [7:0]          o_condition_code,
  input wire                o_irq_hold,
  input wire                o_maskable_irq_block,
  input wire [2:0]          o_mask_level,
  input wire                o_trace_request,
  input wire [63:0]         o_mul_acc_result
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire mod = i_exr_op inside {3'h1, 3'h3, 3'h4, 3'h5};
  fetch_even_a: assert property (o_fetch_addr[0] == 1'h0) else $error("odd fetch");
  narrow_addr_a: assert property ((!i_wide_addr)[*5] |-> o_fetch_addr[23:16] == 8'h00)
    else $error("narrow fetch out of range");
  exr_rsvd_a: assert property (o_extended_control[6:3] == 4'hF) else $error("rsvd");
  hold_three_a: assert property (mod |=> o_irq_hold[*3]) else $error("hold short");
  hold_end_a: assert property (mod ##1 (!mod)[*3] |=> !o_irq_hold) else $error("hold long");
  store_nohold_a: assert property (i_exr_op == 3'h2 && !o_irq_hold |=> !o_irq_hold)
    else $error("store held irqs");
  mask_block_a: assert property (o_maskable_irq_block == o_condition_code[7])
    else $error("block mismatch");
  exc_mask_a: assert property (i_exception_start |=> o_condition_code[7]) else $error("exc");
  trace_req_a: assert property (o_trace_request == $past(i_insn_done && o_extended_control[7]))
    else $error("trace request");
  mac_sign_a: assert property (o_mul_acc_result[63:42] == {22{o_mul_acc_result[41]}})
    else $error("mac sign");
  level_view_a: assert property (o_mask_level == o_extended_control[2:0])
    else $error("level");
  cover property (mod ##1 o_irq_hold);
  cover property (o_trace_request);
  cover property (i_exception_start);
endmodule // crs_register_set_sva
bind crs_register_set crs_register_set_sva #(.PC_WIDTH(PC_WIDTH)) u_sva (.i_clock, .i_nrst,
  .i_wide_addr, .i_exr_op, .i_exception_start, .i_insn_done, .o_fetch_addr, .o_extended_control,
  .o_condition_code, .o_irq_hold, .o_maskable_irq_block, .o_mask_level, .o_trace_request,
  .o_mul_acc_result);

// ### dv/crs_exec_model.sv
// execution-side model: reset vector, retire and exception pulses
`timescale 1ns/100ps
module crs_exec_model (
  input  wire        i_clock,
  output reg         o_vec_valid,
  output reg  [23:0] o_vec,
  output reg         o_done,
  output reg         o_exc
);
  initial {o_vec_valid, o_vec, o_done, o_exc} = '0;
  task vector(input [23:0] v, input int lag);
    repeat (lag) @(posedge i_clock);
    o_vec <= v;
    o_vec_valid <= 1'h1;
    @(posedge i_clock);
    o_vec_valid <= 1'h0;
    o_vec <= ~v;
  endtask
  task pulse(input bit exc);
    @(posedge i_clock);
    if (exc) o_exc <= 1'h1;
    else o_done <= 1'h1;
    @(posedge i_clock);
    o_exc <= 1'h0;
    o_done <= 1'h0;
    #1;
  endtask
endmodule // crs_exec_model

// ### dv/tb.sv
// self-checking bench for the cpu register set
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  reg         i_clock, i_nrst, i_wide_addr, i_gpr_we, i_gpr_wbyte_hi, i_gpr_rbyte_hi, i_sp_we;
  reg         i_pc_load, i_flags_we, i_mac_we_lo, i_mac_we_hi;
  reg  [1:0]  i_gpr_wview, i_gpr_rview;
  reg  [2:0]  i_gpr_waddr, i_gpr_raddr, i_exr_op, i_ccr_op;
  reg  [3:0]  i_flags_nzvc, i_branch_cond;
  reg  [7:0]  i_exr_operand, i_ccr_operand;
  reg  [23:0] i_pc_wdata;
  reg  [31:0] i_gpr_wdata, i_sp_wdata, i_mac_wdata;
  wire        i_insn_done, i_exception_start, i_reset_vector_valid, o_branch_taken;
  wire        o_trace_request, o_irq_hold, o_maskable_irq_block;
  wire [2:0]  o_mask_level;
  wire [7:0]  o_extended_control, o_condition_code;
  wire [23:0] i_reset_vector, o_pc, o_fetch_addr;
  wire [31:0] o_gpr_rdata, o_stack_pointer;
  wire [63:0] o_mul_acc_result;
  int         mismatches, n_checks;
  crs_register_set u_dut (.i_clock, .i_nrst, .i_wide_addr, .i_gpr_waddr, .i_gpr_wview,
    .i_gpr_wbyte_hi, .i_gpr_we, .i_gpr_wdata, .i_gpr_raddr, .i_gpr_rview, .i_gpr_rbyte_hi,
    .o_gpr_rdata, .i_sp_we, .i_sp_wdata, .o_stack_pointer, .i_pc_load, .i_pc_wdata,
    .i_reset_vector_valid, .i_reset_vector, .o_pc, .o_fetch_addr, .i_exr_op, .i_exr_operand,
    .o_extended_control, .i_ccr_op, .i_ccr_operand, .i_flags_we, .i_flags_nzvc,
    .i_exception_start, .o_condition_code, .i_branch_cond, .o_branch_taken, .i_insn_done,
    .o_trace_request, .o_irq_hold, .o_maskable_irq_block, .o_mask_level, .i_mac_we_lo,
    .i_mac_we_hi, .i_mac_wdata, .o_mul_acc_result);
  crs_exec_model u_cpu (.i_clock, .o_vec_valid(i_reset_vector_valid), .o_vec(i_reset_vector),
    .o_done(i_insn_done), .o_exc(i_exception_start));
  always #5 i_clock = ~i_clock;
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task op(input bit x, input [2:0] o, input [7:0] d);
    @(posedge i_clock);
    i_exr_op <= x ? o : 3'h0;
    i_ccr_op <= x ? 3'h0 : o;
    i_exr_operand <= d;
    i_ccr_operand <= d;
    @(posedge i_clock);
    i_exr_op <= 3'h0;
    i_ccr_op <= 3'h0;
    #1;
  endtask
  task wr(input [2:0] a, input [1:0] v, input bit bh, input [31:0] d);
    @(posedge i_clock);
    {i_gpr_we, i_gpr_waddr, i_gpr_wview, i_gpr_wbyte_hi, i_gpr_wdata} <= {1'h1, a, v, bh, d};
    @(posedge i_clock);
    i_gpr_we <= 1'h0;
  endtask
  task rd(input [2:0] a, input [1:0] v, input bit bh, input [31:0] e);
    @(posedge i_clock);
    {i_gpr_raddr, i_gpr_rview, i_gpr_rbyte_hi} <= {a, v, bh};
    @(posedge i_clock);
    #1 `CHK(o_gpr_rdata, e)
  endtask
  task s_reset;
    u_cpu.vector(24'h012345, 6);
    @(posedge i_clock);
    #1 `CHK(o_pc, 24'h012345)
    `CHK(o_fetch_addr, 24'h012344)
    `CHK(o_extended_control, 8'h7F)
    `CHK({o_condition_code[7], o_maskable_irq_block, o_mask_level}, 5'h1F)
  endtask
  task s_gpr;
    wr(3'h2, 2'h0, 1'h0, 32'h11223344);
    wr(3'h2, 2'h3, 1'h1, 32'h000000AB);
    wr(3'h2, 2'h1, 1'h0, 32'h00005566);
    rd(3'h2, 2'h0, 1'h0, 32'h5566AB44);
    rd(3'h2, 2'h1, 1'h0, 32'h00005566);
    rd(3'h2, 2'h2, 1'h0, 32'h0000AB44);
    rd(3'h2, 2'h3, 1'h1, 32'h000000AB);
    rd(3'h2, 2'h3, 1'h0, 32'h00000044);
    @(posedge i_clock);
    {i_sp_we, i_sp_wdata, i_gpr_we, i_gpr_wdata} <= {1'h1, 32'hCAFE0010, 1'h1, 32'h0000DEAD};
    @(posedge i_clock);
    {i_sp_we, i_gpr_we} <= 2'h0;
    rd(3'h7, 2'h0, 1'h0, 32'hCAFE0010);
    rd(3'h2, 2'h1, 1'h0, 32'h00005566);
    `CHK(o_stack_pointer, 32'hCAFE0010)
  endtask
  task s_exr;
    op(1'h1, 3'h1, 8'h05);
    `CHK(o_extended_control, 8'h7D)
    repeat (2) begin
      `CHK(o_irq_hold, 1'h1)
      @(posedge i_clock);
      #1;
    end
    `CHK(o_irq_hold, 1'h1)
    @(posedge i_clock);
    #1 `CHK(o_irq_hold, 1'h0)
    op(1'h1, 3'h3, 8'h00);
    `CHK(o_extended_control, 8'h78)
    op(1'h1, 3'h4, 8'h83);
    `CHK(o_extended_control, 8'hFB)
    op(1'h1, 3'h5, 8'h81);
    `CHK(o_extended_control, 8'h7A)
    repeat (3) @(posedge i_clock);
    op(1'h1, 3'h2, 8'h00);
    `CHK(o_extended_control, 8'h7A)
    `CHK(o_irq_hold, 1'h0)
  endtask
  task s_trace;
    op(1'h1, 3'h4, 8'h80);
    u_cpu.pulse(1'h0);
    `CHK(o_trace_request, 1'h1)
    op(1'h1, 3'h3, 8'h7F);
    u_cpu.pulse(1'h0);
    `CHK(o_trace_request, 1'h0)
  endtask
  task s_ccr;
    op(1'h0, 3'h1, 8'h40);
    `CHK({o_condition_code, o_maskable_irq_block}, 9'h080)
    u_cpu.pulse(1'h1);
    `CHK({o_condition_code, o_maskable_irq_block}, 9'h181)
    op(1'h0, 3'h5, 8'h84);
    `CHK(o_condition_code, 8'h44)
    @(posedge i_clock);
    i_branch_cond <= 4'h7;
    #1 `CHK(o_branch_taken, 1'h1)
    @(posedge i_clock);
    i_branch_cond <= 4'h6;
    #1 `CHK(o_branch_taken, 1'h0)
    @(posedge i_clock);
    {i_flags_we, i_flags_nzvc, i_branch_cond} <= {1'h1, 4'h1, 4'h5};
    @(posedge i_clock);
    i_flags_we <= 1'h0;
    #1 `CHK({o_condition_code, o_branch_taken}, 9'h083)
    op(1'h0, 3'h2, 8'hFF);
    `CHK(o_condition_code, 8'h41)
  endtask
  task s_pc_mac;
    @(posedge i_clock);
    {i_pc_load, i_pc_wdata, i_mac_we_lo, i_mac_we_hi} <= {1'h1, 24'hABCDE7, 2'h3};
    i_mac_wdata <= 32'h00000200;
    @(posedge i_clock);
    {i_pc_load, i_mac_we_hi} <= 2'h0;
    #1 `CHK({o_pc, o_fetch_addr}, 48'hABCDE7ABCDE6)
    `CHK(o_mul_acc_result, 64'hFFFFFE0000000200)
    @(posedge i_clock);
    i_wide_addr <= 1'h0;
    repeat (4) @(posedge i_clock);
    #1 `CHK(o_fetch_addr, 24'h00CDE6)
    @(posedge i_clock);
    i_mac_wdata <= 32'h89ABCDEF;
    @(posedge i_clock);
    i_mac_we_lo <= 1'h0;
    #1 `CHK(o_mul_acc_result, 64'hFFFFFE0089ABCDEF)
  endtask
  initial begin
    {i_clock, i_nrst, i_gpr_we, i_gpr_wbyte_hi, i_gpr_rbyte_hi, i_sp_we, i_pc_load} = '0;
    {i_flags_we, i_mac_we_lo, i_mac_we_hi, i_gpr_wview, i_gpr_rview, i_gpr_waddr} = '0;
    {i_gpr_raddr, i_exr_op, i_ccr_op, i_flags_nzvc, i_branch_cond, i_exr_operand} = '0;
    {i_ccr_operand, i_pc_wdata, i_gpr_wdata, i_sp_wdata, i_mac_wdata} = '0;
    i_wide_addr = 1'h1;
    repeat (12) @(posedge i_clock);
    i_nrst <= 1'h1;
    s_reset;
    s_gpr;
    s_exr;
    s_trace;
    s_ccr;
    s_pc_mac;
    complete_run;
  end
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end
endmodule // tb
